/* fps_pkg.sv */
`default_nettype none
package fps_pkg;
   localparam int CLK_HZ = 25000000;
   localparam int OSC_HZ = 50000;
   localparam int OSC_PERIOD_CYC = CLK_HZ / OSC_HZ;
   localparam int DUTY_MAX_PCT = 67;
   localparam int ON_MAX_CYC = OSC_PERIOD_CYC * DUTY_MAX_PCT / 100;
   localparam int BLANK_NS = 250;
   localparam int BLANK_CYC = (BLANK_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int OLP_DELAY_MS = 100;
   localparam int OLP_DELAY_CYC = (CLK_HZ / 1000) * OLP_DELAY_MS;
   localparam int RESTART_MS = 1600;
   localparam int RESTART_CYC = (CLK_HZ / 1000) * RESTART_MS;
   localparam int SYNC_STAGES = 3;
endpackage
`default_nettype wire

/* fps_sequencer.sv */
// Operation
// - charge source stays on until rail reaches start threshold, then off
// - in normal running the internal regulator is active only while the rail is not above regulation level
// - regulator off while bias winding holds rail above regulation level
// - pulse ends when sense reaches the feedback-derived current level
// - current reference clamped when feedback exceeds clamp level
// - termination comparator ignored for blanking interval after turn-on
// - any fault stops switching at once and starts protection timing
// - while protection timer runs, regulator on and switching disabled
// - at restart duration the regulator is turned off so rail falls
// - rail at stop threshold clears protection and re-enables charge source
// - rail at start threshold resumes switching; repeats while fault persists
// - overload timer starts when feedback at or above overload threshold
// - feedback above threshold for whole delay declares overload fault
// - abnormal current monitor enabled only while gate is on
// - sense above abnormal level forces gate off and protection entry
// - rail above over-voltage threshold triggers protection
// - temperature above shutdown threshold triggers protection
// - restart after thermal fault needs temperature back below hysteresis
// - line sense above threshold triggers protection
// - after line fault, switching held off until line below lower level
`default_nettype none
module fps_sequencer #(
   parameter int OLP_CYC = fps_pkg::OLP_DELAY_CYC,
   parameter int RESTART_CYCLES = fps_pkg::RESTART_CYC
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic railAboveStart,
   input wire logic railAboveStop,
   input wire logic railAboveReg,
   input wire logic railAboveOvp,
   input wire logic senseAboveFb,
   input wire logic senseAboveClamp,
   input wire logic fbAboveClamp,
   input wire logic fbAboveOlp,
   input wire logic senseAboveAbnormal,
   input wire logic tempAboveShutdown,
   input wire logic tempBelowHyst,
   input wire logic lineAboveHigh,
   input wire logic lineBelowLow,
   output logic gateOn,
   output logic hvChargeSourceEn,
   output logic internalHvRegulatorEn,
   output logic faultLatched,
   output logic overloadFault,
   output logic abnormalCurrentFault,
   output logic railOvervoltageFault,
   output logic thermalFault,
   output logic lineOvervoltageFault
);
   typedef enum logic [3:0] {
      ST_CHARGE = 4'b0001,
      ST_RUN = 4'b0010,
      ST_PROT = 4'b0100,
      ST_DISCHG = 4'b1000
   } fps_state_t;

   localparam int NIN = 13;
   logic [NIN-1:0] rawIn;
   logic [NIN-1:0] s1, s2, s3, filt_r;
   assign rawIn = {railAboveStart, railAboveStop, railAboveReg, railAboveOvp,
                   senseAboveFb, senseAboveClamp, fbAboveClamp, fbAboveOlp,
                   senseAboveAbnormal, tempAboveShutdown, tempBelowHyst,
                   lineAboveHigh, lineBelowLow};

   // three stages; a change is accepted only when stages two and three agree
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         filt_r <= '0;
      end
      else
      begin
         s1 <= rawIn;
         s2 <= s1;
         s3 <= s2;
         for (int i = 0; i < NIN; i++)
            if (s2[i] == s3[i])
               filt_r[i] <= s3[i];
      end
   end

   logic fStart, fStop, fReg, fOvp, fSense, fSenseClamp, fFbClamp, fFbOlp;
   logic fAbn, fTemp, fTempLow, fLineHi, fLineLo;
   assign {fStart, fStop, fReg, fOvp, fSense, fSenseClamp, fFbClamp, fFbOlp,
           fAbn, fTemp, fTempLow, fLineHi, fLineLo} = filt_r;

   fps_state_t state_r;
   logic [15:0] oscCnt_r;
   logic [15:0] blankCnt_r;
   logic [31:0] olpCnt_r;
   logic [31:0] restartCnt_r;
   logic anyFault;
   logic restartDone;
   logic holdOff;
   logic endPulse;

   assign restartDone = (restartCnt_r >= 32'(RESTART_CYCLES - 1));
   // thermal and line faults keep holding off while their condition remains
   assign holdOff = (thermalFault && !fTempLow)
                  || (lineOvervoltageFault && !fLineLo);
   assign anyFault = overloadFault || abnormalCurrentFault
                   || railOvervoltageFault || thermalFault
                   || lineOvervoltageFault;

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         state_r <= ST_CHARGE;
      else
         case (state_r)
            ST_CHARGE:
               if (fStart && !holdOff)
                  state_r <= ST_RUN;
            ST_RUN:
               if (anyFault)
                  state_r <= ST_PROT;
            ST_PROT:
               if (restartDone)
                  state_r <= ST_DISCHG;
            ST_DISCHG:
               if (!fStop)
                  state_r <= ST_CHARGE;
            default:
               state_r <= ST_CHARGE;
         endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         restartCnt_r <= '0;
      else if (state_r == ST_PROT && !restartDone)
         restartCnt_r <= restartCnt_r + 32'd1;
      else if (state_r != ST_PROT)
         restartCnt_r <= '0;
   end

   // oscillator and pulse timing
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         oscCnt_r <= '0;
      else if (oscCnt_r == 16'(fps_pkg::OSC_PERIOD_CYC - 1))
         oscCnt_r <= '0;
      else
         oscCnt_r <= oscCnt_r + 16'd1;
   end

   // clamp: above the clamp level the fixed limit comparator rules instead
   assign endPulse = (blankCnt_r == '0)
                   && (fFbClamp ? fSenseClamp : fSense);

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         gateOn <= 1'b0;
         blankCnt_r <= '0;
      end
      else if (state_r != ST_RUN || anyFault || (gateOn && fAbn))
      begin
         gateOn <= 1'b0;
         blankCnt_r <= '0;
      end
      else if (oscCnt_r == '0)
      begin
         gateOn <= 1'b1;
         blankCnt_r <= 16'(fps_pkg::BLANK_CYC);
      end
      else
      begin
         if (blankCnt_r != '0)
            blankCnt_r <= blankCnt_r - 16'd1;
         if (endPulse || oscCnt_r >= 16'(fps_pkg::ON_MAX_CYC))
            gateOn <= 1'b0;
      end
   end

   // overload delay timer
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         olpCnt_r <= '0;
      else if (state_r != ST_RUN || !fFbOlp)
         olpCnt_r <= '0;
      else if (olpCnt_r < 32'(OLP_CYC))
         olpCnt_r <= olpCnt_r + 32'd1;
   end

   // faults latch until the rail reaches the stop level; thermal and line faults stay while their condition remains
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         overloadFault <= 1'b0;
         abnormalCurrentFault <= 1'b0;
         railOvervoltageFault <= 1'b0;
         thermalFault <= 1'b0;
         lineOvervoltageFault <= 1'b0;
      end
      else if (state_r == ST_DISCHG && !fStop)
      begin
         overloadFault <= 1'b0;
         abnormalCurrentFault <= 1'b0;
         railOvervoltageFault <= 1'b0;
         thermalFault <= thermalFault && !fTempLow;
         lineOvervoltageFault <= lineOvervoltageFault && !fLineLo;
      end
      else
      begin
         if (olpCnt_r == 32'(OLP_CYC))
            overloadFault <= 1'b1;
         if (gateOn && fAbn)
            abnormalCurrentFault <= 1'b1;
         if (fOvp)
            railOvervoltageFault <= 1'b1;
         if (fTemp)
            thermalFault <= 1'b1;
         if (fLineHi)
            lineOvervoltageFault <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         hvChargeSourceEn <= 1'b1;
         internalHvRegulatorEn <= 1'b0;
         faultLatched <= 1'b0;
      end
      else
      begin
         hvChargeSourceEn <= (state_r == ST_CHARGE) && !fStart;
         internalHvRegulatorEn <= (state_r == ST_PROT && !restartDone)
                                || (state_r == ST_RUN && !fReg);
         faultLatched <= anyFault;
      end
   end

   chk_fault_stops_gate:
      assert property (@(posedge ref_clk) disable iff (!reset_n)
         anyFault |=> !gateOn)
      else $error("gate on after fault");
   chk_abnormal_kill:
      assert property (@(posedge ref_clk) disable iff (!reset_n)
         (gateOn && fAbn) |=> ##1 (abnormalCurrentFault && !gateOn))
      else $error("abnormal current did not kill gate");
   chk_blank_hold:
      assert property (@(posedge ref_clk) disable iff (!reset_n)
         ($rose(gateOn) && !anyFault && state_r == ST_RUN) |->
         (blankCnt_r == 16'(fps_pkg::BLANK_CYC)))
      else $error("blanking not loaded at turn-on");
   chk_charge_off:
      assert property (@(posedge ref_clk) disable iff (!reset_n)
         fStart |=> !hvChargeSourceEn)
      else $error("charge source on above start");
   chk_prot_reg:
      assert property (@(posedge ref_clk) disable iff (!reset_n)
         (state_r == ST_PROT && !restartDone) |=> internalHvRegulatorEn)
      else $error("regulator off during protection timing");
   chk_restart_reg_off:
      assert property (@(posedge ref_clk) disable iff (!reset_n)
         (state_r == ST_DISCHG) |=> !internalHvRegulatorEn)
      else $error("regulator on after restart time");
   chk_olp_clear:
      assert property (@(posedge ref_clk) disable iff (!reset_n)
         !fFbOlp |=> (olpCnt_r == '0))
      else $error("overload timer not cleared");
   chk_ovp_set:
      assert property (@(posedge ref_clk) disable iff (!reset_n)
         (fOvp && !(state_r == ST_DISCHG && !fStop)) |=> railOvervoltageFault)
      else $error("over-voltage not latched");
   chk_reg_bias:
      assert property (@(posedge ref_clk) disable iff (!reset_n)
         (state_r == ST_RUN && fReg) |=> !internalHvRegulatorEn)
      else $error("regulator on with bias winding");
   chk_olp_fire:
      assert property (@(posedge ref_clk) disable iff (!reset_n)
         (olpCnt_r == 32'(OLP_CYC) && state_r == ST_RUN) |=> overloadFault)
      else $error("overload not declared after delay");
   chk_fault_reset:
      assert property (@(posedge ref_clk) disable iff (!reset_n)
         (state_r == ST_DISCHG && !fStop) |=> !overloadFault)
      else $error("protection not cleared at stop level");
   chk_charge_on:
      assert property (@(posedge ref_clk) disable iff (!reset_n)
         (state_r == ST_CHARGE && !fStart) |=> hvChargeSourceEn)
      else $error("charge source off below start");
   chk_temp_set:
      assert property (@(posedge ref_clk) disable iff (!reset_n)
         (fTemp && state_r != ST_DISCHG) |=> thermalFault)
      else $error("thermal fault not latched");
endmodule
`default_nettype wire

/* fps_stage_model.sv */
`default_nettype none
module fps_stage_model (
   input wire logic ref_clk,
   input wire logic gateOn,
   input wire logic hvChargeSourceEn,
   input wire logic internalHvRegulatorEn,
   input wire logic biasOn,
   input wire logic overV,
   input wire logic abnormal,
   input wire logic [15:0] fbCyc,
   input wire logic [15:0] clampCyc,
   output logic railAboveStart,
   output logic railAboveStop,
   output logic railAboveReg,
   output logic railAboveOvp,
   output logic senseAboveFb,
   output logic senseAboveClamp,
   output logic senseAboveAbnormal
);
   timeunit 1ns;
   timeprecision 1ns;
   // rail in tenths of a volt, one step a cycle keeps the run short
   int railDv = 0;
   int onCnt = 0;
   always @(posedge ref_clk)
   begin
      onCnt <= gateOn ? onCnt + 1 : 0;
      if (overV) railDv <= 250;
      else if (biasOn) railDv <= 140;
      else if (hvChargeSourceEn) railDv <= railDv + 1;
      else if (internalHvRegulatorEn)
         railDv <= (railDv > 100) ? railDv - 1 : 100;
      else if (railDv > 0) railDv <= railDv - 1;
   end
   assign railAboveStart = railDv >= 120;
   assign railAboveStop = railDv > 80;
   assign railAboveReg = railDv > 100;
   assign railAboveOvp = railDv > 245;
   // no switch current flows while the gate is off
   assign senseAboveFb = gateOn && onCnt >= fbCyc;
   assign senseAboveClamp = gateOn && onCnt >= clampCyc;
   assign senseAboveAbnormal = gateOn && abnormal;
endmodule
`default_nettype wire

/* testbench.sv */
`default_nettype none
`define CHK(n, e, a) check(n, e, a)
`define WAITC(c, l) for (int k = 0; k < (l) && !(c); k++) @(negedge ref_clk)
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int OVERLOAD_FAULT = 50;
   localparam int RST = 100;
   logic ref_clk = 0, reset_n = 0, biasOn = 0, overV = 0, abnormal = 0;
   logic fbAboveClamp = 0, fbAboveOlp = 0, tempAboveShutdown = 0;
   logic tempBelowHyst = 1, lineAboveHigh = 0, lineBelowLow = 1;
   logic [15:0] fbCyc = 16'h0064, clampCyc = 16'h0190;
   logic rS, rP, rR, rO, sF, sC, sA;
   logic gateOn, hvChargeSourceEn, internalHvRegulatorEn, faultLatched;
   logic overloadFault, abnormalCurrentFault, railOvervoltageFault;
   logic thermalFault, lineOvervoltageFault;
   int n_fail = 0, total_checks = 0;
   fps_sequencer #(.OLP_CYC(OVERLOAD_FAULT), .RESTART_CYCLES(RST)) uut (.ref_clk,
      .reset_n, .railAboveStart(rS), .railAboveStop(rP), .railAboveReg(rR),
      .railAboveOvp(rO), .senseAboveFb(sF), .senseAboveClamp(sC),
      .fbAboveClamp, .fbAboveOlp, .senseAboveAbnormal(sA),
      .tempAboveShutdown, .tempBelowHyst, .lineAboveHigh, .lineBelowLow,
      .gateOn, .hvChargeSourceEn, .internalHvRegulatorEn, .faultLatched,
      .overloadFault, .abnormalCurrentFault, .railOvervoltageFault,
      .thermalFault, .lineOvervoltageFault);
   fps_stage_model stage (.ref_clk, .gateOn, .hvChargeSourceEn,
      .internalHvRegulatorEn, .biasOn, .overV, .abnormal, .fbCyc, .clampCyc,
      .railAboveStart(rS), .railAboveStop(rP), .railAboveReg(rR),
      .railAboveOvp(rO), .senseAboveFb(sF), .senseAboveClamp(sC),
      .senseAboveAbnormal(sA));
   initial forever #20 ref_clk = ~ref_clk;
   task automatic check(string n, logic [31:0] e, logic [31:0] a);
      total_checks++;
      if (a !== e)
      begin
         n_fail++;
         $display("[ERR] %s expected %0h seen %0h", n, e, a);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic t_pulse(int f, int c, logic cl, int lo, int hi);
      int w;
      @(posedge ref_clk);
      fbCyc <= f[15:0];
      clampCyc <= c[15:0];
      fbAboveClamp <= cl;
      repeat (10) @(negedge ref_clk);
      `WAITC(gateOn === 1'b0, 600);
      `WAITC(gateOn === 1'b1, 600);
      w = 0;
      while (gateOn === 1'b1 && w < 600)
      begin
         @(negedge ref_clk);
         w++;
      end
      `CHK("pulse width", 1, (w >= lo && w <= hi));
   endtask
   // shared auto-restart walk after an overload, abnormal-current or rail over-voltage fault has been seen
   task automatic t_restart();
      repeat (RST - 15) @(negedge ref_clk);
      `CHK("reg during prot", 1, internalHvRegulatorEn);
      `CHK("gate during prot", 0, gateOn);
      `WAITC(internalHvRegulatorEn === 1'b0, 40);
      `CHK("reg after restart", 0, internalHvRegulatorEn);
      `WAITC(hvChargeSourceEn === 1'b1, 300);
      `CHK("charge at stop", 1, hvChargeSourceEn);
      `CHK("fault cleared", 0, faultLatched);
      `WAITC(gateOn === 1'b1, 800);
      `CHK("switching resumed", 1, gateOn);
   endtask
   task automatic t_olp();
      @(posedge ref_clk) fbAboveOlp <= 1;
      repeat (30) @(negedge ref_clk);
      @(posedge ref_clk) fbAboveOlp <= 0;
      repeat (40) @(negedge ref_clk);
      `CHK("short overload", 0, overloadFault);
      @(posedge ref_clk) fbAboveOlp <= 1;
      repeat (45) @(negedge ref_clk);
      `CHK("overload early", 0, overloadFault);
      repeat (20) @(negedge ref_clk);
      `CHK("overload", 1, overloadFault);
      `CHK("gate off", 0, gateOn);
      `CHK("latched", 1, faultLatched);
      @(posedge ref_clk) fbAboveOlp <= 0;
      t_restart();
   endtask
   task automatic t_hyst(logic line);
      @(posedge ref_clk);
      if (line) {lineAboveHigh, lineBelowLow} <= 2'b10;
      else {tempAboveShutdown, tempBelowHyst} <= 2'b10;
      repeat (15) @(negedge ref_clk);
      `CHK("hyst fault", 1, line ? lineOvervoltageFault : thermalFault);
      `CHK("hyst gate", 0, gateOn);
      @(posedge ref_clk);
      lineAboveHigh <= 0;
      tempAboveShutdown <= 0;
      repeat (RST + 400) @(negedge ref_clk);
      `CHK("held off", 0, gateOn);
      @(posedge ref_clk) {lineBelowLow, tempBelowHyst} <= 2'b11;
      `WAITC(gateOn === 1'b1, 900);
      `CHK("hyst restart", 1, gateOn);
   endtask
   initial
   begin
      repeat (60000) @(posedge ref_clk);
      n_fail++;
      close_out();
   end
   initial
   begin
      repeat (4) @(posedge ref_clk);
      reset_n <= 1;
      @(negedge ref_clk);
      `CHK("charge at reset", 1, hvChargeSourceEn);
      `WAITC(hvChargeSourceEn === 1'b0, 300);
      `CHK("start reached", 1, rS);
      // regulator waits until the charged rail sinks to its regulation level
      `WAITC(internalHvRegulatorEn === 1'b1, 100);
      `CHK("reg running", 1, internalHvRegulatorEn);
      t_pulse(30, 400, 0, 30, 37);
      t_pulse(400, 30, 1, 30, 37);
      t_pulse(400, 400, 0, fps_pkg::ON_MAX_CYC, fps_pkg::ON_MAX_CYC + 1);
      t_pulse(1, 400, 0, fps_pkg::BLANK_CYC, fps_pkg::BLANK_CYC + 6);
      biasOn <= 1;
      repeat (20) @(negedge ref_clk);
      `CHK("reg with bias", 0, internalHvRegulatorEn);
      biasOn <= 0;
      repeat (70) @(negedge ref_clk);
      `CHK("reg after bias", 1, internalHvRegulatorEn);
      t_olp();
      abnormal <= 1;
      `WAITC(abnormalCurrentFault === 1'b1, 600);
      `CHK("abnormal fault", 1, abnormalCurrentFault);
      `CHK("abnormal gate", 0, gateOn);
      abnormal <= 0;
      t_restart();
      overV <= 1;
      repeat (15) @(negedge ref_clk);
      `CHK("rail ovp", 1, railOvervoltageFault);
      overV <= 0;
      t_restart();
      t_hyst(0);
      t_hyst(1);
      close_out();
   end
endmodule
`default_nettype wire
